// file: edge_tick.sv
`timescale 1ns/10ps
`default_nettype none
module edge_tick (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic async_in, // Counting clock from its own oscillator
  output logic tick // One-cycle pulse per rising edge of async_in
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      tick <= 1'b0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      tick <= s2_r & ~s3_r;
    end
  end
endmodule : edge_tick
`default_nettype wire

// file: period_lut.sv
`timescale 1ns/10ps
`default_nettype none
module period_lut (
  input wire logic [3:0] code, // Period code
  output logic [14:0] cycles // Counting-clock cycles, 8 shifted by code
);
  // Codes above the last defined one saturate at the longest period
  always_comb begin
    if (code > supervision_timer_pkg::MAX_CODE) begin
      cycles = supervision_timer_pkg::MAX_CYCLES;
    end else begin
      cycles = supervision_timer_pkg::BASE_CYCLES << code;
    end
  end
endmodule : period_lut
`default_nettype wire

// file: supervision_timer.sv
// Overview of operation
// - Reset when period expires without service
// - Early-warning interrupt before time-out
// - Window mode resets on early or late service
// - Counts in active and all sleep states
// - Counts from own clock, not processor clocks
// - Normal periods from 8 to 16k cycles
// - Window total from 16 to 32k cycles
// - Interrupt also serves as wake-up
// - Synchronize enable and service to count clock
// - Counting halts while debugger halts processor
// - Write protection except interrupt flag register
// - One interrupt request line
// - Key 0xA5 restarts, other values reset
// - Config writes discarded while enabled, deferred disabling
// - Disable only when always-on bit clear
// - Window early warning at open phase start
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module supervision_timer (
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read request
  input wire logic avs_write, // Avalon write request
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic count_clock, // Counting clock from low-power oscillator
  input wire logic debug_halt, // Processor halted by debugger
  input wire logic write_protect, // Access protection lock
  output logic sys_reset_req, // System reset request pulse
  output logic irq, // Interrupt request level
  output logic wake_req // Wake-up request level
);
  supervision_timer_pkg::ctl_state_t ctl_state_r;
  logic [7:0] wdat;
  logic wr_acc, wr_lane, wr_prot, ctl_wr, flag_clr, stall;
  logic sel_ctrl, sel_config, sel_ewctrl, sel_mask, sel_flag, sel_clear;
  logic wen_r, aon_r, pend_cfg_v_r, pend_ew_v_r, mask_r, ew_flag_r, clr_pend_r, open_r, rd_ack_r;
  logic [7:0] cfg_r, pend_cfg_r;
  logic [3:0] ew_r, pend_ew_r;
  logic [14:0] cnt_r, limit;
  logic [31:0] rd_data;
  logic tick, run, sw_enable, sync_busy, closed_phase, at_limit, count_tick, clr_apply;
  logic timeout_w, win_open_w, early_clr_w, bad_key_w, ew_normal_w;
  logic [3:0] code_w [3];
  logic [14:0] cyc_w [3];

  // Counting clock edges brought into the system clock domain
  edge_tick u_tick (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(count_clock),
    .tick(tick)
  );

  // Period decoders: open period, closed window, early-warning offset
  assign code_w[0] = cfg_r[supervision_timer_pkg::CFG_PER_LSB +: supervision_timer_pkg::CODE_W];
  assign code_w[1] = cfg_r[supervision_timer_pkg::CFG_WIN_LSB +: supervision_timer_pkg::CODE_W];
  assign code_w[2] = ew_r;
  for (genvar i = 0; i < 3; i++) begin : g_lut
    period_lut u_lut (
      .code(code_w[i]),
      .cycles(cyc_w[i])
    );
  end

  // Bus decode
  assign wdat = avs_writedata[7:0];
  assign sel_ctrl = avs_address == supervision_timer_pkg::OFF_CTRL;
  assign sel_config = avs_address == supervision_timer_pkg::OFF_CONFIG;
  assign sel_ewctrl = avs_address == supervision_timer_pkg::OFF_EWCTRL;
  assign sel_mask = avs_address == supervision_timer_pkg::OFF_IRQ_MASK;
  assign sel_flag = avs_address == supervision_timer_pkg::OFF_IRQ_FLAG;
  assign sel_clear = avs_address == supervision_timer_pkg::OFF_CLEAR;
  assign run = (ctl_state_r == supervision_timer_pkg::CTL_ON) ||
               (ctl_state_r == supervision_timer_pkg::CTL_DISABLING);
  assign sw_enable = (ctl_state_r == supervision_timer_pkg::CTL_ON) ||
                     (ctl_state_r == supervision_timer_pkg::CTL_ENABLING);
  assign sync_busy = clr_pend_r ||
                     (ctl_state_r == supervision_timer_pkg::CTL_ENABLING) ||
                     (ctl_state_r == supervision_timer_pkg::CTL_DISABLING);
  // Writes to synchronized registers wait until the previous one has crossed
  assign stall = avs_write & (sel_ctrl | sel_clear) & sync_busy;
  assign avs_waitrequest = (avs_read & ~rd_ack_r) | stall;
  assign wr_acc = avs_write & ~avs_waitrequest;
  assign wr_lane = wr_acc & avs_byteenable[0];
  assign wr_prot = wr_lane & ~write_protect;
  assign ctl_wr = wr_prot & sel_ctrl;
  assign flag_clr = wr_lane & sel_flag & wdat[supervision_timer_pkg::FLAG_EW];

  // Counting conditions
  assign closed_phase = wen_r & ~open_r;
  assign limit = closed_phase ? cyc_w[1] : cyc_w[0];
  assign at_limit = cnt_r == (limit - 15'h0001);
  // No sleep input gates counting; only a debugger halt does
  assign count_tick = tick & ~debug_halt & run & ~clr_pend_r;
  assign clr_apply = tick & run & clr_pend_r;
  assign timeout_w = count_tick & at_limit & ~closed_phase;
  assign win_open_w = count_tick & at_limit & closed_phase;
  assign early_clr_w = clr_apply & closed_phase;
  assign bad_key_w = wr_prot & sel_clear & (wdat != supervision_timer_pkg::CLEAR_KEY) & run;
  assign ew_normal_w = count_tick & ~wen_r & (cnt_r == (cyc_w[2] - 15'h0001));

  // Enable synchronization
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_state_r <= supervision_timer_pkg::CTL_OFF;
    end else begin
      case (ctl_state_r)
        supervision_timer_pkg::CTL_OFF: begin
          if (ctl_wr & wdat[supervision_timer_pkg::CTRL_ENABLE]) begin
            ctl_state_r <= supervision_timer_pkg::CTL_ENABLING;
          end
        end
        supervision_timer_pkg::CTL_ENABLING: begin
          if (tick) begin
            ctl_state_r <= supervision_timer_pkg::CTL_ON;
          end
        end
        supervision_timer_pkg::CTL_ON: begin
          if (ctl_wr & ~wdat[supervision_timer_pkg::CTRL_ENABLE] & ~aon_r) begin
            ctl_state_r <= supervision_timer_pkg::CTL_DISABLING;
          end
        end
        supervision_timer_pkg::CTL_DISABLING: begin
          if (tick) begin
            ctl_state_r <= supervision_timer_pkg::CTL_OFF;
          end
        end
        default: begin
          ctl_state_r <= supervision_timer_pkg::CTL_OFF;
        end
      endcase
    end
  end

  // Window-enable and always-on bits, only while stopped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wen_r <= 1'b0;
      aon_r <= 1'b0;
    end else if (ctl_wr && ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
      wen_r <= wdat[supervision_timer_pkg::CTRL_WEN];
      aon_r <= wdat[supervision_timer_pkg::CTRL_AON];
    end
  end

  // Configuration: direct while stopped, held over while disabling
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_r <= supervision_timer_pkg::CONFIG_RST;
      pend_cfg_r <= supervision_timer_pkg::CONFIG_RST;
      pend_cfg_v_r <= 1'b0;
    end else begin
      if (wr_prot && sel_config && ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        cfg_r <= wdat;
      end else if (pend_cfg_v_r && ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        cfg_r <= pend_cfg_r;
      end
      if (wr_prot && sel_config && ctl_state_r == supervision_timer_pkg::CTL_DISABLING) begin
        pend_cfg_r <= wdat;
        pend_cfg_v_r <= 1'b1;
      end else if (ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        pend_cfg_v_r <= 1'b0;
      end
    end
  end

  // Early-warning offset, same protection as configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ew_r <= supervision_timer_pkg::EWCTRL_RST;
      pend_ew_r <= supervision_timer_pkg::EWCTRL_RST;
      pend_ew_v_r <= 1'b0;
    end else begin
      if (wr_prot && sel_ewctrl && ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        ew_r <= wdat[supervision_timer_pkg::EW_OFS_LSB +: supervision_timer_pkg::CODE_W];
      end else if (pend_ew_v_r && ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        ew_r <= pend_ew_r;
      end
      if (wr_prot && sel_ewctrl && ctl_state_r == supervision_timer_pkg::CTL_DISABLING) begin
        pend_ew_r <= wdat[supervision_timer_pkg::EW_OFS_LSB +: supervision_timer_pkg::CODE_W];
        pend_ew_v_r <= 1'b1;
      end else if (ctl_state_r == supervision_timer_pkg::CTL_OFF) begin
        pend_ew_v_r <= 1'b0;
      end
    end
  end

  // Service key waits for the next counting clock edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clr_pend_r <= 1'b0;
    end else if (wr_prot && sel_clear && run && wdat == supervision_timer_pkg::CLEAR_KEY) begin
      clr_pend_r <= 1'b1;
    end else if (tick) begin
      clr_pend_r <= 1'b0;
    end
  end

  // Period counter and window phase
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      cnt_r <= '0;
      open_r <= 1'b0;
    end else if (clr_apply) begin
      cnt_r <= '0;
      open_r <= 1'b0;
    end else if (count_tick) begin
      if (at_limit) begin
        cnt_r <= '0;
        open_r <= closed_phase;
      end else begin
        cnt_r <= cnt_r + 15'h0001;
      end
    end
  end

  // System reset request
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= timeout_w | bad_key_w | early_clr_w;
    end
  end

  // Early-warning flag and its enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ew_flag_r <= 1'b0;
    end else begin
      ew_flag_r <= ew_normal_w | win_open_w | (ew_flag_r & ~flag_clr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_r <= 1'b0;
    end else if (wr_prot && sel_mask) begin
      mask_r <= wdat[supervision_timer_pkg::FLAG_EW];
    end
  end

  assign irq = ew_flag_r & mask_r;
  assign wake_req = irq;

  // Read mux
  always_comb begin
    rd_data = '0;
    case (avs_address)
      supervision_timer_pkg::OFF_CTRL: begin
        rd_data[supervision_timer_pkg::CTRL_ENABLE] = sw_enable;
        rd_data[supervision_timer_pkg::CTRL_WEN] = wen_r;
        rd_data[supervision_timer_pkg::CTRL_AON] = aon_r;
      end
      supervision_timer_pkg::OFF_CONFIG: rd_data[7:0] = cfg_r;
      supervision_timer_pkg::OFF_EWCTRL: rd_data[3:0] = ew_r;
      supervision_timer_pkg::OFF_IRQ_MASK: rd_data[supervision_timer_pkg::FLAG_EW] = mask_r;
      supervision_timer_pkg::OFF_IRQ_FLAG: rd_data[supervision_timer_pkg::FLAG_EW] = ew_flag_r;
      supervision_timer_pkg::OFF_STATUS: begin
        rd_data[supervision_timer_pkg::STAT_RUN] = run;
        rd_data[supervision_timer_pkg::STAT_OPEN] = open_r;
        rd_data[supervision_timer_pkg::STAT_SYNCBUSY] = sync_busy;
      end
      supervision_timer_pkg::OFF_COUNT: rd_data[14:0] = cnt_r;
      default: rd_data = '0;
    endcase
  end

  // Reads take one wait state so that read data comes from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_ack_r <= 1'b0;
      avs_readdata <= '0;
    end else begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        avs_readdata <= rd_data;
      end
    end
  end

  property p_timeout_reset;
    @(posedge clk_sys) disable iff (sys_rst)
    (count_tick && at_limit && !closed_phase) |=> sys_reset_req;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("Expired period gave no reset");

  property p_early_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    (clr_apply && wen_r && !open_r) |=> (sys_reset_req && cnt_r == 15'h0000);
  endproperty
  a_early_clear: assert property (p_early_clear)
    else $error("Service in closed phase gave no reset");

  property p_bad_key;
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_prot && sel_clear && run && wdat != supervision_timer_pkg::CLEAR_KEY) |=> sys_reset_req;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("Wrong service key gave no reset");

  property p_window_ew;
    @(posedge clk_sys) disable iff (sys_rst)
    (count_tick && at_limit && wen_r && !open_r) |=> (ew_flag_r && open_r && !sys_reset_req);
  endproperty
  a_window_ew: assert property (p_window_ew)
    else $error("Open phase start raised no early warning");

  property p_flag_sticky;
    @(posedge clk_sys) disable iff (sys_rst)
    (ew_flag_r && !(wr_lane && sel_flag && wdat[0])) |=> ew_flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("Early-warning flag dropped without a clear");

  property p_protect_cfg;
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_acc && sel_config && sw_enable) |=> $stable(cfg_r);
  endproperty
  a_protect_cfg: assert property (p_protect_cfg)
    else $error("Configuration changed while enabled");

  property p_always_on;
    @(posedge clk_sys) disable iff (sys_rst)
    (ctl_wr && aon_r && ctl_state_r == supervision_timer_pkg::CTL_ON) |=>
      (ctl_state_r == supervision_timer_pkg::CTL_ON);
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("Always-on unit stopped");

  property p_debug_halt;
    @(posedge clk_sys) disable iff (sys_rst)
    (debug_halt && !clr_pend_r && run && $past(run)) |=> $stable(cnt_r) || !run;
  endproperty
  a_debug_halt: assert property (p_debug_halt)
    else $error("Counter moved during debug halt");

  property p_write_lock;
    @(posedge clk_sys) disable iff (sys_rst)
    (write_protect && wr_acc && sel_mask) |=> $stable(mask_r);
  endproperty
  a_write_lock: assert property (p_write_lock)
    else $error("Locked register was written");

  property p_sync_stall;
    @(posedge clk_sys) disable iff (sys_rst)
    (avs_write && sel_clear && clr_pend_r) |-> avs_waitrequest;
  endproperty
  a_sync_stall: assert property (p_sync_stall)
    else $error("Service write not held during synchronization");

  property p_irq_line;
    @(posedge clk_sys) disable iff (sys_rst)
    (irq && !flag_clr && !(wr_prot && sel_mask)) |=> (irq && wake_req);
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("Interrupt line disagrees with flag and enable");

endmodule : supervision_timer
`default_nettype wire

// file: supervision_timer_pkg.sv
`default_nettype none
package supervision_timer_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_EWCTRL = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CLEAR = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1C;

  // Field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_WEN = 1;
  localparam int CTRL_AON = 2;
  localparam int CFG_PER_LSB = 0;
  localparam int CFG_WIN_LSB = 4;
  localparam int EW_OFS_LSB = 0;
  localparam int CODE_W = 4;
  localparam int FLAG_EW = 0;
  localparam int STAT_RUN = 0;
  localparam int STAT_OPEN = 1;
  localparam int STAT_SYNCBUSY = 7;

  // Reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [3:0] EWCTRL_RST = 4'h0;

  // Service key and period encoding
  localparam logic [7:0] CLEAR_KEY = 8'hA5;
  localparam int CNT_W = 15;
  localparam logic [14:0] BASE_CYCLES = 15'h0008;
  localparam logic [3:0] MAX_CODE = 4'hB;
  localparam logic [14:0] MAX_CYCLES = 15'h4000;

  typedef enum logic [1:0] {
    CTL_OFF = 2'b00,
    CTL_ENABLING = 2'b01,
    CTL_ON = 2'b10,
    CTL_DISABLING = 2'b11
  } ctl_state_t;

endpackage : supervision_timer_pkg
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int CC = 8; // Count clock period in system clock cycles
  localparam logic [7:0] A_CTRL = supervision_timer_pkg::OFF_CTRL;
  localparam logic [7:0] A_CFG = supervision_timer_pkg::OFF_CONFIG;
  localparam logic [7:0] A_EW = supervision_timer_pkg::OFF_EWCTRL;
  localparam logic [7:0] A_MASK = supervision_timer_pkg::OFF_IRQ_MASK;
  localparam logic [7:0] A_FLAG = supervision_timer_pkg::OFF_IRQ_FLAG;
  localparam logic [7:0] A_STAT = supervision_timer_pkg::OFF_STATUS;
  localparam logic [7:0] A_CLR = supervision_timer_pkg::OFF_CLEAR;
  localparam logic [7:0] A_CNT = supervision_timer_pkg::OFF_COUNT;
  typedef struct packed {logic we; logic [7:0] addr; logic [31:0] data; logic [31:0] exp;} row_t;
  logic clk_sys, sys_rst, avs_read, avs_write, count_clock, debug_halt, write_protect;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, sys_reset_req, irq, wake_req, got;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_rst = 0;
  int t0, t1;
  row_t rows [13];

  supervision_timer u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_clock(count_clock), .debug_halt(debug_halt), .write_protect(write_protect),
    .sys_reset_req(sys_reset_req), .irq(irq), .wake_req(wake_req)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Free-running slow count clock, unrelated to the bus traffic
  initial begin
    count_clock = 1'b0;
    forever begin
      repeat (CC / 2) @(posedge clk_sys);
      count_clock <= ~count_clock;
    end
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Request is held until the edge that samples waitrequest low
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 500);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      final_report();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rchk

  task automatic wait_rst(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys);
      if (sys_reset_req === 1'b1) begin
        got = 1'b1;
        t1 = cyc;
      end
    end
  endtask : wait_rst

  task automatic wait_irq(input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clk_sys);
      if (irq === 1'b1) got = 1'b1;
    end
  endtask : wait_irq

  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic start(input logic [31:0] ctl, cfg, ew, msk);
    wr(A_CFG, cfg);
    wr(A_EW, ew);
    wr(A_MASK, msk);
    wr(A_CTRL, ctl);
  endtask : start

  initial begin
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    debug_halt = 1'b0;
    write_protect = 1'b0;
    rows = '{'{1'b0, A_CTRL, 32'h0, 32'h0}, '{1'b0, A_CFG, 32'h0, 32'h0},
             '{1'b0, A_EW, 32'h0, 32'h0}, '{1'b0, A_MASK, 32'h0, 32'h0},
             '{1'b0, A_FLAG, 32'h0, 32'h0}, '{1'b0, A_STAT, 32'h0, 32'h0},
             '{1'b0, A_CNT, 32'h0, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
             '{1'b1, A_CFG, 32'hFFFFFFB3, 32'hB3}, '{1'b1, A_EW, 32'h7, 32'h7},
             '{1'b1, A_MASK, 32'h1, 32'h1}, '{1'b1, A_CTRL, 32'h6, 32'h6},
             '{1'b1, 8'h20, 32'hFF, 32'h0}};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].addr, rows[i].data);
      rchk("reg_table", rows[i].addr, rows[i].exp);
    end
    // Unserviced expiry spacing for the shortest periods
    for (int k = 0; k < 3; k++) begin
      do_reset();
      start(32'h1, 32'(k), 32'h0, 32'h0);
      wait_rst((8 << k) * CC + 40);
      t0 = t1;
      wait_rst((8 << k) * CC + 40);
      chk("timeout_seen", 32'(got), 32'h1);
      chk("timeout_gap", 32'(t1 - t0), 32'((8 << k) * CC));
    end
    // Regular service holds off expiry, a wrong key resets at once
    do_reset();
    start(32'h1, 32'h1, 32'h0, 32'h0);
    t0 = n_rst;
    repeat (6) begin
      repeat (10 * CC) @(posedge clk_sys);
      wr(A_CLR, 32'hA5);
    end
    chk("serviced_resets", 32'(n_rst - t0), 32'h0);
    wr(A_CLR, 32'h5A);
    wait_rst(4);
    chk("bad_key_reset", 32'(got), 32'h1);
    // Normal early warning, sticky flag and write protection
    do_reset();
    start(32'h1, 32'h1, 32'h0, 32'h1);
    t0 = n_rst;
    wait_irq(20 * CC);
    chk("ew_irq", 32'(irq), 32'h1);
    chk("ew_wake", 32'(wake_req), 32'h1);
    chk("ew_early", 32'(n_rst - t0), 32'h0);
    rchk("ew_flag", A_FLAG, 32'h1);
    write_protect <= 1'b1;
    wr(A_MASK, 32'h0);
    wr(A_FLAG, 32'h1);
    @(posedge clk_sys);
    chk("flag_clear_irq", 32'(irq), 32'h0);
    rchk("mask_locked", A_MASK, 32'h1);
    write_protect <= 1'b0;
    wr(A_MASK, 32'h0);
    repeat (20 * CC) @(posedge clk_sys);
    chk("masked_irq", 32'(irq), 32'h0);
    rchk("masked_flag", A_FLAG, 32'h1);
    // Disable just after a count clock fall, so the next write meets the disabling state
    @(negedge count_clock);
    wr(A_CTRL, 32'h0);
    wr(A_CFG, 32'h2);
    rchk("cfg_deferred", A_CFG, 32'h1);
    repeat (2 * CC) @(posedge clk_sys);
    rchk("cfg_applied", A_CFG, 32'h2);
    rchk("disabled", A_STAT, 32'h0);
    // Window mode: open-phase warning, early and timely service, total period
    do_reset();
    rchk("ctrl_after_reset", A_CTRL, 32'h0);
    start(32'h3, 32'h0, 32'h0, 32'h1);
    wait_rst(40 * CC);
    t0 = t1;
    wr(A_FLAG, 32'h1);
    wait_irq(20 * CC);
    chk("open_delay", 32'(cyc - t0 >= 8 * CC - 4 && cyc - t0 <= 8 * CC + 4), 32'h1);
    rchk("open_status", A_STAT, 32'h3);
    wr(A_CLR, 32'hA5);
    wait_rst(3 * CC);
    chk("open_service", 32'(got), 32'h0);
    wr(A_CLR, 32'hA5);
    wait_rst(3 * CC);
    chk("closed_service", 32'(got), 32'h1);
    wait_rst(20 * CC);
    t0 = t1;
    wait_rst(20 * CC);
    chk("window_gap", 32'(t1 - t0), 32'(16 * CC));
    // Always-on, enable protection and debug halt
    do_reset();
    start(32'h5, 32'h0, 32'h0, 32'h0);
    wr(A_CFG, 32'h3);
    rchk("cfg_locked", A_CFG, 32'h0);
    wr(A_CTRL, 32'h0);
    repeat (3 * CC) @(posedge clk_sys);
    bus(1'b0, A_STAT, 32'h0);
    chk("aon_running", rd & 32'h1, 32'h1);
    debug_halt <= 1'b1;
    repeat (2 * CC) @(posedge clk_sys);
    bus(1'b0, A_CNT, 32'h0);
    t0 = int'(rd);
    wait_rst(30 * CC);
    chk("halt_no_reset", 32'(got), 32'h0);
    rchk("halt_count", A_CNT, 32'(t0));
    debug_halt <= 1'b0;
    wait_rst(10 * CC);
    chk("resume_reset", 32'(got), 32'h1);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
